/* File: design/rppsc_top.sv */
// rx port page select, link capability and raw embedded type control
// assumes one access per cycle from the i2c slave, source tagged local or back channel
// Contract
// - paged addresses 0x4d-0x7f and 0xd0-0xdf are steered by the source's page state
// - read selector bit 4 picks port 0 or port 1 for paged readback
// - local and each back-channel source keep independent page state
// - bit 6 reads 0 locally, carrying port number over back channel
// - read selector resets to 0 locally, to carrying port over back channel
// - write enables reset 0 locally; back channel sets only the carrying port
// - line count 0 forwards all as raw; 1..3 marks first lines embedded
// - embedded lines use the six-bit embedded code, reset 0x12
// - substitution ignored while the port receives csi-2 formatted data
// - crc flagging needs capability bit set and encoder crc disable clear
//
// notes for the next engineer
// - the paged banks live outside; only strobes, the page hit and the read choice leave here
// - three page contexts: local, back channel on port 0, back channel on port 1
// - a context is chosen from the tag on the access itself, so two sources
//   interleaving their accesses never see each other's selections
// - back-channel contexts take their carrying-port defaults at reset only;
//   they are not reloaded when a link drops, software rewrites them if needed
// - read data is one cycle late; the i2c slave must wait a cycle before using it
// - line counting saturates at three, the deepest substitution on offer
// - the crc flag is a one-cycle pulse per reported encoder crc error
// - shared registers hold every bit written, reserved ones included
//
`timescale 1ns/1ps
`include "rppsc_regs.svh"
module rppsc_top import rppsc_pkg::*; (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // register access
    input  wire rppsc_acc_s acc,
    output logic [7:0]      rdata,
    // paged register fabric
    output logic [1:0]      page_wr,
    output logic            page_rd_port,
    input  wire logic [7:0] page_rdata_0,
    input  wire logic [7:0] page_rdata_1,
    output logic            page_hit,
    // datapath controls
    input  wire logic       csi_mode,
    input  wire logic       frame_start,
    input  wire logic       long_pkt,
    input  wire logic [5:0] raw_type_code,
    output logic [5:0]      pkt_type_code,
    input  wire logic       encoder_crc_disable,
    input  wire logic       encoder_crc_err,
    output logic            encoder_crc_flag
);
    logic [7:0]  cap_q;
    logic [7:0]  emb_q;
    rppsc_page_s ctx_q [3];
    logic [1:0]  line_q;
    logic [1:0]  src;
    rppsc_page_s cur;
    logic [7:0]  sel_rd;

    // decoded fields of the shared registers
    logic [1:0]  emb_line_count;
    logic [5:0]  emb_code;
    logic        crc_flag_enable;

    // access qualifiers, decoded once so every process sees the same hit
    logic        wr_sel;
    logic        wr_cap;
    logic        wr_emb;
    logic        rd_sel;
    logic        rd_cap;
    logic        rd_emb;

    // datapath gates and the next line count
    logic        sub_active;
    logic        crc_gate;
    logic [1:0]  line_d;

    // exact register address match, shared by the write and read decoders
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
        addr_is = (a == r);
    endfunction : addr_is

    // readback bank choice; the bank not chosen is never looked at
    function automatic logic [7:0] bank_pick(input logic       p,
                                             input logic [7:0] b0,
                                             input logic [7:0] b1);
        bank_pick = p ? b1 : b0;
    endfunction : bank_pick

    // field views of the shared registers
    assign emb_line_count  = emb_q[7:6];
    assign emb_code        = emb_q[5:0];
    assign crc_flag_enable = cap_q[`RPPSC_CAP_CRC_BIT];

    // write strobes per shared register; a paged write never matches these
    assign wr_sel = acc.wr && addr_is(acc.addr, `RPPSC_SEL_ADDR);
    assign wr_cap = acc.wr && addr_is(acc.addr, `RPPSC_CAP_ADDR);
    assign wr_emb = acc.wr && addr_is(acc.addr, `RPPSC_EMB_ADDR);

    // read strobes per shared register
    assign rd_sel = acc.rd && addr_is(acc.addr, `RPPSC_SEL_ADDR);
    assign rd_cap = acc.rd && addr_is(acc.addr, `RPPSC_CAP_ADDR);
    assign rd_emb = acc.rd && addr_is(acc.addr, `RPPSC_EMB_ADDR);

    // substitution only in raw mode and only for the first lines of a frame
    assign sub_active = !csi_mode && (line_q < emb_line_count);

    // two gates in series; either one alone keeps the flag quiet
    assign crc_gate = crc_flag_enable & ~encoder_crc_disable;

    // next line count; saturating so a long frame never wraps into substitution
    always_comb begin
        line_d = line_q;
        if (frame_start)
            line_d = 2'd0;
        else if (long_pkt && line_q != 2'd3)
            line_d = line_q + 2'd1;
    end

    function automatic logic is_paged(input logic [7:0] a);
        is_paged = (a >= `RPPSC_PAGE_A_LO && a <= `RPPSC_PAGE_A_HI) ||
                   (a >= `RPPSC_PAGE_B_LO && a <= `RPPSC_PAGE_B_HI);
    endfunction : is_paged

    // source index: 0 local, 1 back channel port 0, 2 back channel port 1
    assign src = acc.bcc ? (acc.link ? 2'd2 : 2'd1) : 2'd0;
    assign cur = ctx_q[src];
    assign page_hit = is_paged(acc.addr);
    assign page_rd_port = cur.read_port;
    assign page_wr = (acc.wr && page_hit) ? cur.write_en : 2'b00;

    // select register view; reserved bits zero
    always_comb begin
        sel_rd = 8'h00;
        sel_rd[`RPPSC_SEL_PHYS_BIT] = acc.bcc & acc.link;
        sel_rd[`RPPSC_SEL_READ_BIT] = cur.read_port;
        sel_rd[1:0] = cur.write_en;
    end

    // page contexts; back channel defaults follow the carrying port
    // only the context of the source making this access is written, so a
    // remote host paging its own view can never redirect a local write
    // reserved select bits are not stored at all, hence read back as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctx_q[0] <= '{read_port: 1'b0, write_en: 2'b00};
            ctx_q[1] <= '{read_port: 1'b0, write_en: 2'b01};
            ctx_q[2] <= '{read_port: 1'b1, write_en: 2'b10};
        end else if (wr_sel) begin
            ctx_q[src].read_port <= acc.wdata[`RPPSC_SEL_READ_BIT];
            ctx_q[src].write_en  <= acc.wdata[1:0];
        end
    end

    // capability register, shared by all sources; only bit 4 has a job here
    always_ff @(posedge clk) begin
        if (!nrst)
            cap_q <= `RPPSC_CAP_RST;
        else if (wr_cap)
            cap_q <= acc.wdata;
    end

    // embedded type register, shared by all sources
    always_ff @(posedge clk) begin
        if (!nrst)
            emb_q <= `RPPSC_EMB_RST;
        else if (wr_emb)
            emb_q <= acc.wdata;
    end

    // read data registered one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (acc.rd) begin
            if (page_hit)
                rdata <= bank_pick(cur.read_port, page_rdata_0, page_rdata_1);
            else if (rd_cap)
                rdata <= cap_q;
            else if (rd_emb)
                rdata <= emb_q;
            else if (rd_sel)
                rdata <= sel_rd;
            else
                rdata <= 8'h00;
        end
    end

    // long packets seen since frame start, saturating at three
    always_ff @(posedge clk) begin
        if (!nrst)
            line_q <= 2'd0;
        else
            line_q <= line_d;
    end

    // type substitution; csi mode keeps the incoming code
    always_ff @(posedge clk) begin
        if (!nrst)
            pkt_type_code <= 6'h00;
        else if (sub_active)
            pkt_type_code <= emb_code;
        else
            pkt_type_code <= raw_type_code;
    end

    // crc flag needs both the capability bit and the disable cleared
    always_ff @(posedge clk) begin
        if (!nrst)
            encoder_crc_flag <= 1'b0;
        else
            encoder_crc_flag <= encoder_crc_err & crc_gate;
    end
endmodule : rppsc_top

/* File: pkg/rppsc_regs.svh */
// register offsets, fields, reset values for the rx port page select block
// assumes byte-wide registers on an 8-bit i2c register address
`ifndef RPPSC_REGS_SVH
`define RPPSC_REGS_SVH
`define RPPSC_CAP_ADDR        8'h4a
`define RPPSC_EMB_ADDR        8'h4b
`define RPPSC_SEL_ADDR        8'h4c
`define RPPSC_PAGE_A_LO       8'h4d
`define RPPSC_PAGE_A_HI       8'h7f
`define RPPSC_PAGE_B_LO       8'hd0
`define RPPSC_PAGE_B_HI       8'hdf
`define RPPSC_CAP_RST         8'h00
`define RPPSC_EMB_RST         8'h12
`define RPPSC_CAP_CRC_BIT     4
`define RPPSC_SEL_PHYS_BIT    6
`define RPPSC_SEL_READ_BIT    4
`define RPPSC_SEL_WMASK       8'h13
`endif

/* File: pkg/rppsc_pkg.sv */
// types for the rx port page select block
// assumes rppsc_regs.svh is on the include path
package rppsc_pkg;
    // one register access from a source
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bcc;
        logic       link;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rppsc_acc_s;
    // per-source page context
    typedef struct packed {
        logic       read_port;
        logic [1:0] write_en;
    } rppsc_page_s;
endpackage : rppsc_pkg

/* File: testbench/rppsc_bank_model.sv */
// paged register banks for rx ports 0 and 1
// assumes page strobes qualify wdata in the same cycle
`timescale 1ns/1ps
module rppsc_bank_model (
    // fabric side
    input wire logic       clk,
    input wire logic [1:0] wr,
    input wire logic [7:0] wdata,
    output logic [7:0]     q0,
    output logic [7:0]     q1
);
    // each bank latches on its own strobe only
    always_ff @(posedge clk) begin
        if (wr[0]) q0 <= wdata;
        if (wr[1]) q1 <= wdata;
    end
endmodule : rppsc_bank_model

/* File: testbench/rppsc_sva.sv */
// port checker for rppsc_top
// assumes the bind below attaches it to every instance
`timescale 1ns/1ps
`include "rppsc_regs.svh"
module rppsc_sva import rppsc_pkg::*; (
    input wire logic       clk, nrst, page_hit, csi_mode, long_pkt,
    input wire rppsc_acc_s acc,
    input wire logic [7:0] rdata,
    input wire logic [1:0] page_wr,
    input wire logic [5:0] raw_type_code, pkt_type_code,
    input wire logic       encoder_crc_disable, encoder_crc_err, encoder_crc_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // select register read strobe
    wire sel_rd = acc.rd && acc.addr == `RPPSC_SEL_ADDR;
    a_local_phys_zero: assert property (sel_rd && !acc.bcc |=> !rdata[6]) else $error("phys");
    a_bcc_phys_port: assert property (sel_rd && acc.bcc |=> rdata[6] == $past(acc.link))
        else $error("bcc phys");
    a_reserved_zero: assert property (sel_rd |=> (rdata & 8'hac) == 8'h00) else $error("rsv");
    a_idle_no_strobe: assert property (!acc.wr || !page_hit |-> page_wr == 2'b00)
        else $error("strobe");
    a_page_hit_range: assert property (page_hit == (acc.addr inside
        {[`RPPSC_PAGE_A_LO:`RPPSC_PAGE_A_HI], [`RPPSC_PAGE_B_LO:`RPPSC_PAGE_B_HI]}))
        else $error("hit");
    a_unmapped_zero: assert property (acc.rd && acc.addr == 8'h00 |=> rdata == 8'h00)
        else $error("unmapped");
    a_csi_keeps_raw: assert property (csi_mode && long_pkt |=> pkt_type_code == $past(raw_type_code))
        else $error("csi");
    a_crc_flag_cause: assert property (encoder_crc_flag |-> $past(encoder_crc_err && !encoder_crc_disable))
        else $error("crc");
endmodule : rppsc_sva
bind rppsc_top rppsc_sva u_sva (.clk, .nrst, .page_hit, .csi_mode, .long_pkt, .acc, .rdata,
    .page_wr, .raw_type_code, .pkt_type_code, .encoder_crc_disable, .encoder_crc_err, .encoder_crc_flag);

/* File: testbench/rppsc_tb_top.sv */
// self-checking bench for rppsc_top
// assumes bank model and bound checker compiled alongside
`timescale 1ns/1ps
`include "rppsc_regs.svh"
module rppsc_tb_top import rppsc_pkg::*; ;
    logic       clk = 0, nrst = 0, csi = 0, fs = 0, lp = 0, dis = 0, err = 0, rp, hit, flag;
    rppsc_acc_s acc = '0;
    logic [7:0] rdata, q0, q1;
    logic [1:0] pwr;
    logic [5:0] code;
    int         fails = 0, check_count = 0;
    initial forever #5 clk = ~clk;
    rppsc_top i_dut (.clk, .nrst, .acc, .rdata, .page_wr(pwr), .page_rd_port(rp),
        .page_rdata_0(q0), .page_rdata_1(q1), .page_hit(hit), .csi_mode(csi), .frame_start(fs),
        .long_pkt(lp), .raw_type_code(6'h2a), .pkt_type_code(code),
        .encoder_crc_disable(dis), .encoder_crc_err(err), .encoder_crc_flag(flag));
    rppsc_bank_model i_bank (.clk, .wr(pwr), .wdata(acc.wdata), .q0, .q1);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one strobe cycle; read data is settled on return
    task automatic go(input logic w, b, l, input logic [7:0] a, d);
        @(posedge clk) #1 acc = '{w, !w, b, l, a, d};
        @(posedge clk) #1 acc.wr = 0;
        acc.rd = 0;
    endtask : go
    task automatic rd(input logic b, l, input logic [7:0] a, e);
        go(0, b, l, a, 8'h00);
        chk(rdata, e);
    endtask : rd
    task automatic pulse(ref logic s);
        @(posedge clk) #1 s = 1;
        @(posedge clk) #1 s = 0;
    endtask : pulse
    // reset values as seen from each source
    task automatic t_reset_values;
        rd(0, 0, `RPPSC_CAP_ADDR, 8'h00);
        rd(0, 0, `RPPSC_EMB_ADDR, 8'h12);
        rd(0, 0, `RPPSC_SEL_ADDR, 8'h00);
        chk({7'h00, hit}, 8'h00);
        rd(1, 0, `RPPSC_SEL_ADDR, 8'h01);
        rd(1, 1, `RPPSC_SEL_ADDR, 8'h52);
        rd(0, 0, 8'h00, 8'h00);
    endtask : t_reset_values
    // broadcast, single-port and discarded paged writes, then source isolation
    task automatic t_paging;
        go(1, 0, 0, `RPPSC_SEL_ADDR, 8'hff);
        rd(0, 0, `RPPSC_SEL_ADDR, 8'h13);
        go(1, 0, 0, 8'h4d, 8'ha5);
        go(1, 0, 0, `RPPSC_SEL_ADDR, 8'h01);
        go(1, 0, 0, 8'hd0, 8'h3c);
        rd(0, 0, 8'hd0, 8'h3c);
        chk({7'h00, hit}, 8'h01);
        chk({7'h00, rp}, 8'h00);
        go(1, 0, 0, `RPPSC_SEL_ADDR, 8'h10);
        go(1, 0, 0, 8'hd0, 8'h77);
        rd(0, 0, 8'h4d, 8'ha5);
        chk({7'h00, rp}, 8'h01);
        rd(0, 0, 8'hd0, 8'ha5);
        go(1, 1, 0, `RPPSC_SEL_ADDR, 8'h00);
        rd(0, 0, `RPPSC_SEL_ADDR, 8'h10);
        rd(1, 1, `RPPSC_SEL_ADDR, 8'h52);
    endtask : t_paging
    // linecount 2 raw, then csi, then linecount 0
    task automatic t_embedded;
        for (int m = 0; m < 3; m++) begin
            go(1, 0, 0, `RPPSC_EMB_ADDR, m == 2 ? 8'h2b : 8'hab);
            csi = m == 1;
            pulse(fs);
            for (int n = 0; n < 3; n++) begin
                pulse(lp);
                chk({2'b00, code}, (m == 0 && n < 2) ? 8'h2b : 8'h2a);
            end
        end
    endtask : t_embedded
    // crc flag against capability bit and disable input
    task automatic t_crc;
        for (int m = 0; m < 3; m++) begin
            go(1, 0, 0, `RPPSC_CAP_ADDR, m ? 8'h10 : 8'h00);
            dis = m == 2;
            pulse(err);
            chk({7'h00, flag}, {7'h00, m == 1});
        end
    endtask : t_crc
    initial begin
        repeat (12) @(posedge clk);
        #1 nrst = 1;
        t_reset_values;
        t_paging;
        t_embedded;
        t_crc;
        print_verdict;
    end
    // generous cap over a run of under a hundred cycles
    initial begin
        #20000;
        fails++;
        print_verdict;
    end
    task automatic print_verdict;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
endmodule : rppsc_tb_top
